// [verilog/cfbie_pkg.sv]
package cfbie_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFS_BANK  = 8'h04;
  localparam logic [7:0] OFS_ACC   = 8'h05;
  localparam logic [7:0] OFS_FLAGS = 8'h0A;
  localparam logic [7:0] OFS_IRQ0  = 8'h0B;
  localparam logic [7:0] OFS_IRQ1  = 8'h1E;
  localparam logic [7:0] OFS_EDGE  = 8'h3A;
  localparam logic [7:0] SFR_END   = 8'h40;
  // ==========================================
  // Field positions
  localparam int F_C = 0, F_AC = 1, F_Z = 2, F_OV = 3, F_PDF = 4, F_TO = 5;
  localparam int I0_GATE = 0, I0_EXT = 4, I0_T0 = 5, I0_T1 = 6;
  localparam int I1_MF = 4, I1_AD = 5, I1_TK = 6;
  localparam int EN_LO = 0, FL_LO = 4;
  // ==========================================
  // Masks and reset values
  localparam logic [7:0] FLAGS_SW_MASK = 8'h0F;
  localparam logic [7:0] IRQ0_MASK     = 8'h7F;
  localparam logic [7:0] IRQ1_MASK     = 8'h77;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [1:0] RST_EDGE      = 2'h0;
  localparam logic [7:0] VEC_STEP      = 8'h04;
  localparam int         NSRC          = 6;
  // ==========================================
  // Edge choice for the external pin
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // ==========================================
  // ALU operations
  localparam logic [3:0] OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBC = 4'h3;
  localparam logic [3:0] OP_DAA = 4'h4, OP_AND = 4'h5, OP_OR  = 4'h6, OP_XOR = 4'h7;
  localparam logic [3:0] OP_CPL = 4'h8, OP_RL  = 4'h9, OP_RR  = 4'hA, OP_RLC = 4'hB;
  localparam logic [3:0] OP_RRC = 4'hC, OP_INC = 4'hD, OP_DEC = 4'hE, OP_MOV = 4'hF;

  typedef struct packed {
    logic       valid;
    logic [3:0] op;
    logic       use_acc;
    logic       to_acc;
    logic [7:0] a;
    logic [7:0] b;
  } cfbie_alu_req_t;

  typedef struct packed {
    logic       timer0;
    logic       timer1;
    logic       adc;
    logic       tkey;
    logic [2:0] member;
  } cfbie_irq_src_t;
endpackage

// [verilog/cfbie_core.sv]
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module cfbie_core (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  // Register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  // ALU request and result
  input  wire cfbie_pkg::cfbie_alu_req_t alu_req,
  output logic      [7:0]               alu_result,
  // Data memory bank mapping
  input  wire logic [7:0]               dm_addr,
  input  wire logic                     dm_indirect,
  output logic                          dm_bank,
  output logic                          bank_choice_bit,
  // Sequencer events
  input  wire logic                     halt_op,
  input  wire logic                     watchdog_clear_op,
  input  wire logic                     watchdog_timeout,
  input  wire logic                     watchdog_reset,
  input  wire logic                     return_from_irq,
  input  wire logic                     instr_boundary,
  input  wire logic                     stack_full,
  // Interrupt sources
  input  wire logic                     ext_irq_pin,
  input  wire cfbie_pkg::cfbie_irq_src_t irq_src,
  // Interrupt entry and power-down
  output logic                          irq_take,
  output logic      [7:0]               irq_vector,
  output logic                          powered_down,
  output logic                          wake
);
  import cfbie_pkg::*;

  // ==========================================
  // Reset release
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================
  // Registers
  logic       bank;
  logic [7:0] working_register;
  logic [5:0] cpu_flags;
  logic [7:0] irq_ctrl_first;
  logic [7:0] irq_ctrl_second;
  logic [1:0] edge_sel;
  logic       global_irq_gate;
  logic       ext_irq_pending, timer_zero_pending, timer_one_pending;
  logic       halt_entered_flag, watchdog_expired_flag;

  assign global_irq_gate       = irq_ctrl_first[I0_GATE];
  assign ext_irq_pending       = irq_ctrl_first[I0_EXT];
  assign timer_zero_pending    = irq_ctrl_first[I0_T0];
  assign timer_one_pending     = irq_ctrl_first[I0_T1];
  assign halt_entered_flag     = cpu_flags[F_PDF];
  assign watchdog_expired_flag = cpu_flags[F_TO];

  logic wr_bank, wr_acc, wr_flags, wr_irq0, wr_irq1, wr_edge;
  assign wr_bank  = reg_wr && reg_addr == OFS_BANK;
  assign wr_acc   = reg_wr && reg_addr == OFS_ACC;
  assign wr_flags = reg_wr && reg_addr == OFS_FLAGS;
  assign wr_irq0  = reg_wr && reg_addr == OFS_IRQ0;
  assign wr_irq1  = reg_wr && reg_addr == OFS_IRQ1;
  assign wr_edge  = reg_wr && reg_addr == OFS_EDGE;

  // ==========================================
  // Bank selection and address mapping
  function automatic logic bank_of(input logic [7:0] addr, input logic ind,
                                   input logic sel);
    // Special registers and direct accesses never leave bank 0
    bank_of = (addr >= SFR_END) && ind && sel;
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank <= 1'b0;
    end else if (watchdog_reset) begin
      if (!powered_down) begin
        bank <= 1'b0;
      end
    end else if (wr_bank) begin
      bank <= reg_wdata[0];
    end
  end
  assign bank_choice_bit = bank;
  assign dm_bank = bank_of(dm_addr, dm_indirect, bank);

  // ==========================================
  // ALU
  logic [7:0] op_a, bop, res;
  logic [8:0] sum, daa_t;
  logic [4:0] nib;
  logic       cin, c_in7;
  logic [3:0] fval, fmask;

  assign op_a = alu_req.use_acc ? working_register : alu_req.a;

  always_comb begin
    bop   = alu_req.b;
    cin   = 1'b0;
    res   = 8'h00;
    fval  = 4'h0;
    fmask = 4'h0;
    daa_t = 9'h000;
    case (alu_req.op)
      OP_ADC: cin = cpu_flags[F_C];
      OP_SUB: begin
        bop = ~alu_req.b;
        cin = 1'b1;
      end
      OP_SBC: begin
        bop = ~alu_req.b;
        cin = cpu_flags[F_C];
      end
      default: ;
    endcase
    // Subtract is add of the complement, so carry means no borrow
    sum   = {1'b0, op_a} + {1'b0, bop} + {8'h00, cin};
    nib   = {1'b0, op_a[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
    c_in7 = op_a[7] ^ bop[7] ^ sum[7];
    case (alu_req.op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        res   = sum[7:0];
        fval  = {c_in7 ^ sum[8], sum[7:0] == 8'h00, nib[4], sum[8]};
        fmask = 4'hF;
      end
      OP_DAA: begin
        daa_t = {1'b0, op_a};
        if (op_a[3:0] > 4'h9 || cpu_flags[F_AC]) begin
          daa_t = daa_t + 9'h006;
        end
        if (daa_t[8:4] > 5'h09 || cpu_flags[F_C]) begin
          daa_t = daa_t + 9'h060;
        end
        res   = daa_t[7:0];
        fval  = {3'h0, daa_t[8] | cpu_flags[F_C]};
        fmask = 4'h1;
      end
      OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC: begin
        case (alu_req.op)
          OP_AND:  res = op_a & alu_req.b;
          OP_OR:   res = op_a | alu_req.b;
          OP_XOR:  res = op_a ^ alu_req.b;
          OP_CPL:  res = ~op_a;
          OP_INC:  res = op_a + 8'h01;
          default: res = op_a - 8'h01;
        endcase
        fval  = {1'b0, res == 8'h00, 2'h0};
        fmask = 4'h4;
      end
      OP_RL:  res = {op_a[6:0], op_a[7]};
      OP_RR:  res = {op_a[0], op_a[7:1]};
      OP_RLC: begin
        res   = {op_a[6:0], cpu_flags[F_C]};
        fval  = {3'h0, op_a[7]};
        fmask = 4'h1;
      end
      OP_RRC: begin
        res   = {cpu_flags[F_C], op_a[7:1]};
        fval  = {3'h0, op_a[0]};
        fmask = 4'h1;
      end
      default: res = op_a;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_result <= RST_BYTE;
    end else if (alu_req.valid) begin
      alu_result <= res;
    end
  end

  // Moves between memory locations land here first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      working_register <= RST_BYTE;
    end else if (alu_req.valid && alu_req.to_acc) begin
      working_register <= res;
    end else if (wr_acc) begin
      working_register <= reg_wdata;
    end
  end

  // ==========================================
  // Flags; never pushed on interrupt entry
  logic [3:0] arith_next;
  always_comb begin
    arith_next = cpu_flags[3:0];
    if (wr_flags) begin
      arith_next = reg_wdata[3:0] & FLAGS_SW_MASK[3:0];
    end
    if (alu_req.valid) begin
      arith_next = (arith_next & ~fmask) | (fval & fmask);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_flags <= 6'h00;
    end else begin
      cpu_flags[3:0] <= arith_next;
      if (halt_op) begin
        cpu_flags[F_PDF] <= 1'b1;
      end else if (watchdog_clear_op) begin
        cpu_flags[F_PDF] <= 1'b0;
      end
      // Timeout wins over a clear in the same cycle
      if (watchdog_timeout) begin
        cpu_flags[F_TO] <= 1'b1;
      end else if (watchdog_clear_op || halt_op) begin
        cpu_flags[F_TO] <= 1'b0;
      end
    end
  end

  // ==========================================
  // External pin filter
  logic [2:0] pin_sync;
  logic       pin_level, pin_edge;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync  <= 3'h0;
      pin_level <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], ext_irq_pin};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_level <= pin_sync[2];
      end
    end
  end
  always_comb begin
    pin_edge = 1'b0;
    if (pin_sync[1] == pin_sync[2] && pin_sync[2] != pin_level) begin
      case (edge_sel)
        EDGE_RISE: pin_edge = pin_sync[2];
        EDGE_FALL: pin_edge = !pin_sync[2];
        EDGE_BOTH: pin_edge = 1'b1;
        default:   pin_edge = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_sel <= RST_EDGE;
    end else if (wr_edge) begin
      edge_sel <= reg_wdata[1:0];
    end
  end

  // Combined request fires only when member requests rise from none to any
  logic member_any, member_prev;
  assign member_any = |irq_src.member;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      member_prev <= 1'b0;
    end else begin
      member_prev <= member_any;
    end
  end

  // ==========================================
  // Interrupt arbitration
  logic [NSRC-1:0] pend, en, req, sel, hw_set;
  logic            accept;
  assign pend = {irq_ctrl_second[I1_TK:I1_MF], irq_ctrl_first[I0_T1:I0_EXT]};
  assign en   = {irq_ctrl_second[2:0], irq_ctrl_first[3:1]};
  assign req  = pend & en;
  assign hw_set = {irq_src.tkey, irq_src.adc, member_any && !member_prev,
                   irq_src.timer1, irq_src.timer0, pin_edge};
  // Stall while the stack is full; request flags still collect
  assign accept = instr_boundary && global_irq_gate && !stack_full && |req;
  // Lowest index is highest priority
  assign sel = req & (~req + 6'h01);

  function automatic logic [7:0] vector_of(input logic [NSRC-1:0] onehot);
    vector_of = 8'h00;
    for (int i = 0; i < NSRC; i++) begin
      if (onehot[i]) begin
        vector_of = VEC_STEP * 8'(i + 1);
      end
    end
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_take   <= 1'b0;
      irq_vector <= RST_BYTE;
    end else begin
      irq_take <= accept;
      if (accept) begin
        irq_vector <= vector_of(sel);
      end
    end
  end

  // Pending bits: a hardware set beats a write or entry clear in the same cycle, but not a watchdog reset
  logic [NSRC-1:0] pend_next;
  always_comb begin
    pend_next = pend;
    if (wr_irq0) begin
      pend_next[2:0] = reg_wdata[I0_T1:I0_EXT];
    end
    if (wr_irq1) begin
      pend_next[5:3] = reg_wdata[I1_TK:I1_MF];
    end
    if (accept) begin
      pend_next = pend_next & ~sel;
    end
    pend_next = pend_next | hw_set;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ctrl_first  <= RST_BYTE;
      irq_ctrl_second <= RST_BYTE;
    end else if (watchdog_reset) begin
      irq_ctrl_first  <= RST_BYTE;
      irq_ctrl_second <= RST_BYTE;
    end else begin
      irq_ctrl_first[I0_T1:I0_EXT]  <= pend_next[2:0];
      irq_ctrl_second[I1_TK:I1_MF]  <= pend_next[5:3];
      if (wr_irq0) begin
        irq_ctrl_first[3:0] <= reg_wdata[3:0];
      end
      if (wr_irq1) begin
        irq_ctrl_second[2:0] <= reg_wdata[2:0];
      end
      if (accept) begin
        irq_ctrl_first[I0_GATE] <= 1'b0;
      end else if (return_from_irq) begin
        irq_ctrl_first[I0_GATE] <= 1'b1;
      end
    end
  end

  // ==========================================
  // Power-down and wake
  assign wake = powered_down && |req;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      powered_down <= 1'b0;
    end else if (halt_op) begin
      powered_down <= 1'b1;
    end else if (wake || watchdog_timeout || watchdog_reset) begin
      powered_down <= 1'b0;
    end
  end

  // ==========================================
  // Read port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RST_BYTE;
    end else if (!reg_rd) begin
      reg_rdata <= RST_BYTE;
    end else if (reg_addr == OFS_BANK) begin
      reg_rdata <= {7'h00, bank};
    end else if (reg_addr == OFS_ACC) begin
      reg_rdata <= working_register;
    end else if (reg_addr == OFS_FLAGS) begin
      reg_rdata <= {2'h0, cpu_flags};
    end else if (reg_addr == OFS_IRQ0) begin
      reg_rdata <= irq_ctrl_first & IRQ0_MASK;
    end else if (reg_addr == OFS_IRQ1) begin
      reg_rdata <= irq_ctrl_second & IRQ1_MASK;
    end else if (reg_addr == OFS_EDGE) begin
      reg_rdata <= {6'h00, edge_sel};
    end else begin
      reg_rdata <= RST_BYTE;
    end
  end

  // ==========================================
  // Checks
  a_bank_wdt_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    watchdog_reset && powered_down |=> $stable(bank))
    else $error("bank changed on watchdog reset in power-down");
  a_bank_wdt_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    watchdog_reset && !powered_down |=> !bank)
    else $error("bank not cleared by watchdog reset");
  a_take_gate_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept |=> irq_take && !global_irq_gate)
    else $error("gate still open after interrupt entry");
  a_stack_full_block: assert property (@(posedge core_clk) disable iff (!rst_n)
    stack_full |=> !irq_take)
    else $error("interrupt taken with full stack");
  a_ext_vector: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && req[0] |=> irq_vector == 8'h04 && !ext_irq_pending)
    else $error("external entry wrong");
  a_timer_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && !req[0] && req[1] |=> irq_vector == 8'h08)
    else $error("timer 0 priority wrong");
  a_flags_write_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_flags && !halt_op && !watchdog_clear_op && !watchdog_timeout
    |=> $stable(cpu_flags[5:4]))
    else $error("software write changed halt or watchdog flag");
  a_halt_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
    halt_op && !watchdog_timeout |=> halt_entered_flag && !watchdog_expired_flag)
    else $error("halt flags wrong");
  a_return_from_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    return_from_irq && !accept && !wr_irq0 && !watchdog_reset |=> global_irq_gate)
    else $error("gate not reopened on return");
  a_zero_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    alu_req.valid && fmask[F_Z] |=> cpu_flags[F_Z] == (alu_result == 8'h00))
    else $error("zero flag mismatch");
endmodule

// [test/cfbie_seq_model.sv]
`timescale 1ns/1ps
// ==========================================
// Sequencer and return stack stand-in
module cfbie_seq_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Bench commands
  input  wire logic hold,
  input  wire logic ret_req,
  // Core side
  input  wire logic irq_take,
  output logic      return_from_irq,
  output logic      stack_full,
  output logic      instr_boundary
);
  logic [3:0] depth;

  // Only the return address is stacked; flags stay with software
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      depth           <= 4'h0;
      return_from_irq <= 1'b0;
    end else begin
      return_from_irq <= ret_req && depth != 4'h0;
      if (irq_take)
        depth <= depth + 4'h1;
      else if (ret_req && depth != 4'h0)
        depth <= depth - 4'h1;
    end
  end

  assign stack_full     = depth == 4'h8;
  assign instr_boundary = !hold;
endmodule

// [test/cfbie_core_bench.sv]
`timescale 1ns/1ps
module cfbie_core_bench;
  import cfbie_pkg::*;
  logic           core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  logic           dm_ind = 0, ext_pin = 1, hold = 0, ret_req = 0;
  logic [7:0]     reg_addr = 8'h00, reg_wdata = 8'h00, dm_addr = 8'h00;
  logic [7:0]     reg_rdata, alu_result, irq_vector;
  logic [3:0]     ev = 4'h0;
  logic           dm_bank, bank_bit, irq_take, pd, wake, rfi, sfull, ib;
  cfbie_alu_req_t alu_req = '0;
  cfbie_irq_src_t src = '0;
  int             num_errors = 0, checked = 0, cycles = 0;

  initial forever #20 core_clk = ~core_clk;
  // Whole run needs a few hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  cfbie_core i_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .alu_req(alu_req), .alu_result(alu_result),
    .dm_addr(dm_addr), .dm_indirect(dm_ind), .dm_bank(dm_bank),
    .bank_choice_bit(bank_bit), .halt_op(ev[0]), .watchdog_clear_op(ev[1]),
    .watchdog_timeout(ev[2]), .watchdog_reset(ev[3]),
    .return_from_irq(rfi), .instr_boundary(ib), .stack_full(sfull),
    .ext_irq_pin(ext_pin), .irq_src(src), .irq_take(irq_take),
    .irq_vector(irq_vector), .powered_down(pd), .wake(wake)
  );
  cfbie_seq_model i_seq (
    .core_clk(core_clk), .resetn(resetn), .hold(hold), .ret_req(ret_req),
    .irq_take(irq_take), .return_from_irq(rfi), .stack_full(sfull),
    .instr_boundary(ib)
  );

  // ==========================================
  // Shared tasks
  task automatic check(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic do_reset;
    @(posedge core_clk) resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(string n, logic [7:0] a, logic [7:0] e);
    @(posedge core_clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 check(n, e, reg_rdata);
  endtask
  task automatic pulse_ev(logic [3:0] m);
    @(posedge core_clk) ev <= m;
    @(posedge core_clk) ev <= 4'h0;
  endtask
  // Order: timer0, timer1, adc, touch
  task automatic pulse_src(logic [3:0] m);
    @(posedge core_clk) src <= {m, src.member};
    @(posedge core_clk) src <= {4'h0, src.member};
    #1;
  endtask
  task automatic pulse_ret;
    @(posedge core_clk) ret_req <= 1'b1;
    @(posedge core_clk) ret_req <= 1'b0;
  endtask
  task automatic alu(logic [3:0] op, logic [7:0] a, logic [7:0] b, logic [7:0] e);
    @(posedge core_clk) alu_req <= '{1'b1, op, 1'b0, 1'b1, a, b};
    @(posedge core_clk) alu_req.valid <= 1'b0;
    #1 check("alu_result", e, alu_result);
  endtask
  task automatic bank_chk(logic ind, logic [7:0] a, logic e);
    @(posedge core_clk) {dm_ind, dm_addr} <= {ind, a};
    #1 check("dm_bank", {7'h0, e}, {7'h0, dm_bank});
  endtask
  task automatic take_chk(logic [7:0] v);
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk);
      #1;
      if (irq_take === 1'b1)
        break;
    end
    check("irq_take", 8'h01, {7'h0, irq_take});
    check("irq_vector", v, irq_vector);
  endtask
  task automatic none_chk(int n);
    repeat (n) begin
      @(posedge core_clk);
      #1 check("irq_take", 8'h00, {7'h0, irq_take});
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic t_bank;
    do_reset();
    rd_chk("bank", OFS_BANK, 8'h00);
    rd_chk("flags", OFS_FLAGS, 8'h00);
    rd_chk("unmapped", 8'h30, 8'h00);
    wr(OFS_BANK, 8'hFF);
    rd_chk("bank", OFS_BANK, 8'h01);
    check("bank_bit", 8'h01, {7'h0, bank_bit});
    bank_chk(1'b1, 8'h40, 1'b1);
    bank_chk(1'b0, 8'h40, 1'b0);
    bank_chk(1'b1, OFS_FLAGS, 1'b0);
    pulse_ev(4'h8);
    rd_chk("bank", OFS_BANK, 8'h00);
    wr(OFS_BANK, 8'h01);
    pulse_ev(4'h1);
    pulse_ev(4'h8);
    rd_chk("bank", OFS_BANK, 8'h01);
  endtask

  task automatic t_alu;
    do_reset();
    alu(OP_ADD, 8'h7F, 8'h01, 8'h80);
    rd_chk("flags", OFS_FLAGS, 8'h0A);
    rd_chk("acc", OFS_ACC, 8'h80);
    alu(OP_SUB, 8'h05, 8'h05, 8'h00);
    rd_chk("flags", OFS_FLAGS, 8'h07);
    alu(OP_ADD, 8'h80, 8'h80, 8'h00);
    rd_chk("flags", OFS_FLAGS, 8'h0D);
    wr(OFS_FLAGS, 8'hFF);
    rd_chk("flags", OFS_FLAGS, 8'h0F);
  endtask

  task automatic t_power;
    do_reset();
    // Hold entry off so the pending flag stays visible
    hold <= 1'b1;
    pulse_ev(4'h1);
    rd_chk("flags", OFS_FLAGS, 8'h10);
    pulse_ev(4'h4);
    rd_chk("flags", OFS_FLAGS, 8'h30);
    // Timeout woke the core; halt again so the wake path is live
    pulse_ev(4'h1);
    rd_chk("flags", OFS_FLAGS, 8'h10);
    wr(OFS_IRQ0, 8'h05);
    pulse_src(4'h8);
    check("wake", 8'h01, {7'h0, wake});
    pulse_ev(4'h2);
    rd_chk("flags", OFS_FLAGS, 8'h00);
    hold <= 1'b0;
  endtask

  task automatic t_irq;
    do_reset();
    wr(OFS_IRQ0, 8'h0F);
    wr(OFS_IRQ1, 8'h07);
    hold <= 1'b1;
    pulse_src(4'hC);
    hold <= 1'b0;
    take_chk(8'h08);
    rd_chk("irq0", OFS_IRQ0, 8'h4E);
    pulse_ret();
    take_chk(8'h0C);
    rd_chk("irq0", OFS_IRQ0, 8'h0E);
    @(posedge core_clk) src.member <= 3'h2;
    none_chk(6);
    rd_chk("irq1", OFS_IRQ1, 8'h17);
    wr(OFS_IRQ0, 8'h0F);
    take_chk(8'h10);
    rd_chk("irq1", OFS_IRQ1, 8'h07);
    @(posedge core_clk) src.member <= 3'h0;
    wr(OFS_IRQ0, 8'h01);
    pulse_src(4'h3);
    take_chk(8'h14);
    pulse_ret();
    take_chk(8'h18);
    // Falling, then rising, then either edge
    for (int e = 1; e < 4; e++) begin
      wr(OFS_EDGE, 8'(e));
      wr(OFS_IRQ0, 8'h03);
      @(posedge core_clk) ext_pin <= ~ext_pin;
      take_chk(8'h04);
      rd_chk("irq0", OFS_IRQ0, 8'h02);
    end
  endtask

  task automatic t_full;
    do_reset();
    wr(OFS_IRQ0, 8'h05);
    repeat (8) begin
      pulse_src(4'h8);
      take_chk(8'h08);
      wr(OFS_IRQ0, 8'h05);
    end
    pulse_src(4'h8);
    none_chk(8);
    pulse_ret();
    take_chk(8'h08);
  endtask

  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    t_bank();
    t_alu();
    t_power();
    t_irq();
    t_full();
    test_done();
  end
endmodule
